/* usf_config_regs.sv */
// Serial-access configuration bank of the ultrasonic front end
`timescale 1ns/1ps
`default_nettype none
module usf_config_regs
  import usf_pkg::*;
#(
  parameter int DG_LONG_CYC = DG_C0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spiSelN,
  input wire logic spiClk,
  input wire logic spiDataIn,
  output logic spiDataOut,
  output logic spiDataOutEn,
  input wire logic [5:0] filterFreqCode,
  input wire logic filterBypass,
  input wire logic trimOverride,
  input wire logic [2:0] factorySlope,
  input wire logic [3:0] factoryIntercept,
  input wire logic vdrvReady,
  input wire logic pulseNumFault,
  input wire logic eeCrcFault,
  input wire logic [1:0] devState,
  input wire logic burstStart,
  input wire logic burstActive,
  input wire logic driveInputOne,
  input wire logic driveInputTwo,
  output logic [5:0] effFreqCode,
  output logic highPassSelect,
  output logic [1:0] qualityCode,
  output logic [2:0] qualityValue,
  output logic qualityActive,
  output logic [2:0] slopeCode,
  output logic [3:0] interceptCode,
  output logic [9:0] slopeCenti,
  output logic firstStageOff,
  output logic lastStageOff,
  output logic fullScaleHigh,
  output logic [5:0] preampGainHalf,
  output logic [1:0] ioMode,
  output logic [7:0] driveSupplyCtrl,
  output logic driveStuckFault
);

  // ************
  // Declarations
  // ************
  usf_frame_state_t state;
  usf_frame_state_t next_state;
  logic selPrev;
  logic clkPrev;
  logic [4:0] fallCnt;
  logic [4:0] riseCnt;
  logic [15:0] rxShift;
  logic cmdRead;
  logic [5:0] cmdAddr;
  logic prevParErr;
  logic [5:0] statusSnap;
  logic [7:0] filterConfigTwo;
  logic [7:0] logAmpControl;
  logic [7:0] frontEndControl;
  logic [7:0] driveIoControl;
  logic [7:0] driveSupplyControl;
  logic stuckPulse;
  logic [7:0] readByte;

  wire logic frameOpen;
  wire logic frameClose;
  wire logic clkRise;
  wire logic clkFall;
  wire logic frameFull;
  wire logic parityOk;
  wire logic frameGood;
  wire logic wrStrobe;
  wire logic faultClear;
  wire logic [5:0] statusNow;
  wire logic [7:0] txData;
  wire logic txParity;
  wire logic [15:0] txWord;
  wire logic [3:0] txIndex;

  // ************
  // Serial edge detection
  // ************
  always_ff @(posedge mclk) begin
    if (sys_rst) selPrev <= 1'b1;
    else selPrev <= spiSelN;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) clkPrev <= 1'b0;
    else clkPrev <= spiClk;
  end

  assign frameOpen = selPrev && !spiSelN;
  assign frameClose = !selPrev && spiSelN;
  assign clkRise = (state == USF_SHIFT) && spiClk && !clkPrev;
  assign clkFall = (state == USF_SHIFT) && !spiClk && clkPrev;

  // ************
  // Frame state
  // ************
  always_comb begin
    next_state = state;
    case (state)
      USF_IDLE: if (frameOpen) next_state = USF_SHIFT;
      USF_SHIFT: if (frameClose) next_state = USF_CLOSE;
      USF_CLOSE: next_state = USF_IDLE;
      default: next_state = USF_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) state <= USF_IDLE;
    else state <= next_state;
  end

  // ************
  // Receive side
  // ************
  // sixteen bits msb first
  always_ff @(posedge mclk) begin
    if (sys_rst) rxShift <= 16'h0000;
    else if (frameOpen) rxShift <= 16'h0000;
    else if (clkFall) rxShift <= {rxShift[14:0], spiDataIn};
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) fallCnt <= 5'h00;
    else if (frameOpen) fallCnt <= 5'h00;
    else if (clkFall && fallCnt != 5'h1f) fallCnt <= fallCnt + 5'h01;
  end

  // Command latched after the seventh bit so the reply byte is ready
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmdRead <= 1'b0;
      cmdAddr <= 6'h00;
    end else if (frameOpen) begin
      cmdRead <= 1'b0;
      cmdAddr <= 6'h00;
    end else if (clkFall && fallCnt == 5'h06) begin
      cmdRead <= rxShift[5] == CMD_READ;
      cmdAddr <= {rxShift[4:0], spiDataIn};
    end
  end

  assign frameFull = fallCnt == 5'(FRAME_BITS);
  assign parityOk = ^rxShift;
  assign frameGood = (state == USF_CLOSE) && frameFull && parityOk;
  assign wrStrobe = frameGood && !cmdRead;
  assign faultClear = frameGood && cmdRead && cmdAddr == FLT_OFFSET;

  // Short or overlong frames are dropped without flagging parity
  always_ff @(posedge mclk) begin
    if (sys_rst) prevParErr <= 1'b0;
    else if (state == USF_CLOSE && frameFull) prevParErr <= !parityOk;
  end

  // ************
  // Register file
  // ************
  // reset and reserved masks
  always_ff @(posedge mclk) begin
    if (sys_rst) filterConfigTwo <= FC2_RESET;
    else if (wrStrobe && cmdAddr == FC2_OFFSET) filterConfigTwo <= rxShift[7:0] & FC2_MASK;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) logAmpControl <= LAC_RESET;
    else if (wrStrobe && cmdAddr == LAC_OFFSET) logAmpControl <= rxShift[7:0] & LAC_MASK;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) frontEndControl <= FEC_RESET;
    else if (wrStrobe && cmdAddr == FEC_OFFSET) frontEndControl <= rxShift[7:0] & FEC_MASK;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) driveIoControl <= DIO_RESET;
    else if (wrStrobe && cmdAddr == DIO_OFFSET) driveIoControl <= rxShift[7:0] & DIO_MASK;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) driveSupplyControl <= DSC_RESET;
    else if (wrStrobe && cmdAddr == DSC_OFFSET) driveSupplyControl <= rxShift[7:0] & DSC_MASK;
  end

  always_comb begin
    case (cmdAddr)
      FC2_OFFSET: readByte = filterConfigTwo;
      LAC_OFFSET: readByte = logAmpControl;
      FEC_OFFSET: readByte = frontEndControl;
      DIO_OFFSET: readByte = driveIoControl;
      DSC_OFFSET: readByte = driveSupplyControl;
      FLT_OFFSET: readByte = 8'(driveStuckFault) << FLT_STUCK_BIT;
      default: readByte = 8'h00;
    endcase
  end

  // ************
  // Transmit side
  // ************
  // fault in status bit 3
  assign statusNow = {vdrvReady, pulseNumFault, driveStuckFault, eeCrcFault, devState};

  always_ff @(posedge mclk) begin
    if (sys_rst) statusSnap <= 6'h00;
    else if (frameOpen) statusSnap <= statusNow;
  end

  // Writes echo the address back in the data byte
  assign txData = cmdRead ? readByte : {2'b00, cmdAddr};
  assign txParity = ~^{prevParErr, statusSnap, txData};
  assign txWord = {prevParErr, statusSnap, txParity, txData};
  assign txIndex = 4'hf - riseCnt[3:0];

  always_ff @(posedge mclk) begin
    if (sys_rst) riseCnt <= 5'h00;
    else if (frameOpen) riseCnt <= 5'h00;
    else if (clkRise && riseCnt != 5'h1f) riseCnt <= riseCnt + 5'h01;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) spiDataOut <= 1'b0;
    else if (frameOpen) spiDataOut <= 1'b0;
    else if (clkRise && riseCnt < 5'(FRAME_BITS)) spiDataOut <= txWord[txIndex];
  end

  // Line released one mclk after select goes high
  always_ff @(posedge mclk) begin
    if (sys_rst) spiDataOutEn <= 1'b0;
    else spiDataOutEn <= !spiSelN;
  end

  // ************
  // Stuck-drive fault
  // ************
  usf_drive_monitor #(
    .LONG_CYC(DG_LONG_CYC)
  ) u_monitor (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ioMode(driveIoControl[DIO_MODE_LSB +: 2]),
    .dgCode(driveIoControl[DIO_DG_LSB +: 3]),
    .burstStart(burstStart),
    .burstActive(burstActive),
    .driveIn({driveInputTwo, driveInputOne}),
    .stuckPulse(stuckPulse)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) driveStuckFault <= 1'b0;
    else driveStuckFault <= stuckPulse | (driveStuckFault & !faultClear);
  end

  // ************
  // Filter controls
  // ************
  wire logic [1:0] next_qualityCode;
  wire logic [2:0] next_qualityValue;
  wire logic [5:0] next_effFreqCode;

  assign next_qualityCode = filterConfigTwo[FC2_Q_LSB +: 2];
  assign next_qualityValue = (next_qualityCode == 2'h0) ? 3'h4 :
                             (next_qualityCode == 2'h1) ? 3'h5 :
                             (next_qualityCode == 2'h2) ? 3'h2 : 3'h3;
  // trim offset add, wraps at six bits
  assign next_effFreqCode = trimOverride ?
    6'(filterFreqCode + {2'b00, filterConfigTwo[FC2_TRIM_LSB +: 4]}) : filterFreqCode;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      qualityCode <= 2'h0;
      qualityValue <= 3'h4;
      qualityActive <= 1'b0;
      highPassSelect <= 1'b0;
      effFreqCode <= 6'h00;
    end else begin
      qualityCode <= next_qualityCode;
      qualityValue <= next_qualityValue;
      qualityActive <= !filterBypass;
      highPassSelect <= filterBypass;
      effFreqCode <= next_effFreqCode;
    end
  end

  // ************
  // Log amp controls
  // ************
  wire logic [2:0] next_slopeCode;
  wire logic [3:0] next_interceptCode;

  assign next_slopeCode = logAmpControl[LAC_OVR_BIT] ?
    logAmpControl[LAC_SLOPE_LSB +: 3] : factorySlope;
  assign next_interceptCode = logAmpControl[LAC_OVR_BIT] ?
    logAmpControl[LAC_INT_LSB +: 4] : factoryIntercept;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slopeCode <= 3'h0;
      interceptCode <= 4'h0;
    end else begin
      slopeCode <= next_slopeCode;
      interceptCode <= next_interceptCode;
    end
  end

  usf_slope_lut u_slope (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .scaleHigh(frontEndControl[FEC_SCALE_BIT]),
    .slopeCode(next_slopeCode),
    .slopeCenti(slopeCenti)
  );

  // ************
  // Front-end controls
  // ************
  wire logic [1:0] gainCode;
  wire logic [5:0] next_preampGainHalf;

  assign gainCode = frontEndControl[FEC_GAIN_LSB +: 2];
  assign next_preampGainHalf = (gainCode == 2'h0) ? 6'h1e :
                               (gainCode == 2'h1) ? 6'h14 :
                               (gainCode == 2'h2) ? 6'h28 : 6'h19;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      firstStageOff <= 1'b0;
      lastStageOff <= 1'b0;
      fullScaleHigh <= 1'b0;
      preampGainHalf <= 6'h1e;
    end else begin
      firstStageOff <= frontEndControl[FEC_FIRST_BIT];
      lastStageOff <= frontEndControl[FEC_LAST_BIT];
      fullScaleHigh <= frontEndControl[FEC_SCALE_BIT];
      preampGainHalf <= next_preampGainHalf;
    end
  end

  // ************
  // Drive IO and supply
  // ************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ioMode <= 2'h0;
      driveSupplyCtrl <= DSC_RESET;
    end else begin
      ioMode <= driveIoControl[DIO_MODE_LSB +: 2];
      driveSupplyCtrl <= driveSupplyControl;
    end
  end

endmodule // usf_config_regs
`default_nettype wire

/* usf_config_regs_asserts.sv */
// Port-level assertions for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module usf_config_regs_asserts
  import usf_pkg::*;
#(
  parameter int DG_LONG_CYC = DG_C0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spiSelN,
  input wire logic spiDataOutEn,
  input wire logic [5:0] filterFreqCode,
  input wire logic filterBypass,
  input wire logic trimOverride,
  input wire logic burstActive,
  input wire logic driveInputOne,
  input wire logic driveInputTwo,
  input wire logic [5:0] effFreqCode,
  input wire logic highPassSelect,
  input wire logic [1:0] qualityCode,
  input wire logic [2:0] qualityValue,
  input wire logic qualityActive,
  input wire logic [1:0] ioMode,
  input wire logic driveStuckFault
);
  // ************
  // Checks
  // ************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  function automatic logic [2:0] qMap(input logic [1:0] c);
    return (c[1] ? 3'h2 : 3'h4) + {2'h0, c[0]};
  endfunction

  a_bypass_on: assert property (filterBypass [*3] |-> highPassSelect && !qualityActive)
    else $error("bypass not reflected");
  a_bypass_off: assert property (!filterBypass [*3] |-> !highPassSelect && qualityActive)
    else $error("band-pass not reflected");
  a_quality_map: assert property ($stable(qualityCode) [*2] |-> qualityValue == qMap(qualityCode))
    else $error("quality value wrong");
  a_freq_plain: assert property ((!trimOverride && $stable(filterFreqCode)) [*3]
    |-> effFreqCode == filterFreqCode)
    else $error("frequency code altered");
  a_fault_sticky: assert property (spiSelN [*5] ##0 driveStuckFault |=> driveStuckFault)
    else $error("fault flag dropped");
  a_idle_quiet: assert property (!burstActive [*8] ##0 !driveStuckFault |=> !driveStuckFault)
    else $error("fault without burst");
  a_mode_none: assert property ((ioMode == IO_MODE_NONE) [*5] ##0 !driveStuckFault
    |=> !driveStuckFault)
    else $error("fault in unchecked mode");
  a_both_high: assert property ((ioMode == IO_MODE_DUAL && driveInputOne && driveInputTwo) [*6]
    ##0 !driveStuckFault |=> !driveStuckFault)
    else $error("fault while both inputs high");
  a_reply_idle: assert property (spiSelN [*2] |-> !spiDataOutEn)
    else $error("reply driven while idle");
  a_reply_on: assert property (!spiSelN [*2] |-> spiDataOutEn)
    else $error("reply not driven in frame");

  c_fault: cover property ($rose(driveStuckFault));
  c_frame: cover property (!spiSelN [*8]);
  c_both_high: cover property (ioMode == IO_MODE_DUAL && driveInputOne && driveInputTwo);
endmodule // usf_config_regs_asserts

bind usf_config_regs usf_config_regs_asserts #(.DG_LONG_CYC(DG_LONG_CYC)) chkInst (
  .mclk, .sys_rst, .spiSelN, .spiDataOutEn, .filterFreqCode, .filterBypass, .trimOverride,
  .burstActive, .driveInputOne, .driveInputTwo, .effFreqCode, .highPassSelect, .qualityCode,
  .qualityValue, .qualityActive, .ioMode, .driveStuckFault);
`default_nettype wire

/* usf_config_regs_tb_top.sv */
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module usf_config_regs_tb_top;
  import usf_pkg::*;
  // Short long-deglitch count keeps the run brief
  localparam int LONG = 200;
  localparam logic [5:0] AD[5] = '{FC2_OFFSET, LAC_OFFSET, FEC_OFFSET, DIO_OFFSET,
    DSC_OFFSET};
  localparam logic [7:0] MK[5] = '{FC2_MASK, LAC_MASK, FEC_MASK, DIO_MASK, DSC_MASK};
  localparam logic [7:0] RS[5] = '{FC2_RESET, LAC_RESET, FEC_RESET, DIO_RESET, DSC_RESET};
  localparam logic [9:0] SLP[16] = '{10'h12c, 10'h136, 10'h140, 10'h14a, 10'h104, 10'h10e,
    10'h118, 10'h122, 10'h1c8, 10'h1d7, 10'h1e6, 10'h1f5, 10'h18a, 10'h19a, 10'h1a9, 10'h1b8};
  localparam logic [2:0] QV[4] = '{3'h4, 3'h5, 3'h2, 3'h3};
  localparam logic [5:0] GN[4] = '{6'h1e, 6'h14, 6'h28, 6'h19};
  localparam int LM[8] = '{LONG, DG_C1, DG_C2, DG_C3, DG_C4, DG_C5, DG_C6, 700};
  logic mclk, sys_rst, spiSelN, spiClk, spiDataIn, spiDataOut, spiDataOutEn;
  logic [5:0] filterFreqCode, effFreqCode, preampGainHalf;
  logic filterBypass, trimOverride, vdrvReady, pulseNumFault, eeCrcFault;
  logic burstStart, burstActive, driveInputOne, driveInputTwo, highPassSelect;
  logic qualityActive, firstStageOff, lastStageOff, fullScaleHigh, driveStuckFault;
  logic [2:0] factorySlope, qualityValue, slopeCode;
  logic [3:0] factoryIntercept, interceptCode;
  logic [1:0] devState, qualityCode, ioMode;
  logic [9:0] slopeCenti;
  logic [7:0] driveSupplyCtrl;
  logic [7:0] sh[5];
  logic [15:0] r;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  usf_config_regs #(.DG_LONG_CYC(LONG)) uut (.*);
  usf_spi_ctrl_model m (.*);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Hang guard well above the expected run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      test_done();
    end
  end

  // ************
  // Helpers
  // ************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [15:0] fr(input logic rd, input logic [5:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {rd, a, 1'b0, d};
    w[8] = ~^w;
    return w;
  endfunction

  task automatic acc(input logic rd, input logic [5:0] a, input logic [7:0] d);
    m.xfer(fr(rd, a, d), r);
    if (!rd) chk({8'h0, r[7:0]}, {10'h0, a});
  endtask

  task automatic outs();
    logic [2:0] s;
    logic [5:0] f;
    s = sh[1][7] ? sh[1][6:4] : factorySlope;
    f = filterFreqCode + (trimOverride ? {2'h0, sh[0][3:0]} : 6'h0);
    if (!filterBypass) begin
      chk(16'(qualityValue), 16'(QV[sh[0][5:4]]));
      chk(16'(effFreqCode), 16'(f));
    end
    chk(16'({highPassSelect, qualityActive}), 16'({filterBypass, !filterBypass}));
    chk(16'(qualityCode), 16'(sh[0][5:4]));
    chk(16'(slopeCode), 16'(s));
    chk(16'(interceptCode), 16'(sh[1][7] ? sh[1][3:0] : factoryIntercept));
    chk(16'(slopeCenti), 16'(SLP[{sh[2][2], s}]));
    chk(16'({firstStageOff, lastStageOff}), 16'(sh[2][7:6]));
    chk(16'(fullScaleHigh), 16'(sh[2][2]));
    chk(16'(preampGainHalf), 16'(GN[sh[2][1:0]]));
    chk(16'(ioMode), 16'(sh[3][1:0]));
    chk(16'(driveSupplyCtrl), 16'(sh[4]));
  endtask

  task automatic arm(input logic [1:0] md, input logic [2:0] c);
    acc(1'b0, DIO_OFFSET, {3'h0, c, md});
    burstStart <= 1'b1;
    burstActive <= 1'b1;
    driveInputOne <= ~driveInputOne;
    driveInputTwo <= ~driveInputTwo;
    @(posedge mclk);
    burstStart <= 1'b0;
  endtask

  task automatic wt(input int n, input logic t1, input logic t2);
    repeat (n) begin
      @(posedge mclk);
      if (t1 && cyc % 40 == 0) driveInputOne <= ~driveInputOne;
      if (t2 && cyc % 40 == 0) driveInputTwo <= ~driveInputTwo;
    end
  endtask

  task automatic clr(input logic e);
    burstActive <= 1'b0;
    acc(1'b1, FLT_OFFSET, 8'h00);
    chk(16'(r[12]), 16'(e));
    chk(16'(r[FLT_STUCK_BIT]), 16'(e));
    chk(16'(driveStuckFault), 16'h0);
  endtask

  task automatic probe(input logic [1:0] md, input logic t1, input logic t2, input int n,
    input logic e);
    arm(md, 3'h6);
    wt(n, t1, t2);
    chk(16'(driveStuckFault), 16'(e));
    clr(e);
  endtask

  // ************
  // Sequence
  // ************
  initial begin
    int i;
    int unsigned sd;
    logic [7:0] d;
    sys_rst = 1'b1;
    {filterFreqCode, filterBypass, trimOverride, factorySlope, factoryIntercept} = '0;
    {vdrvReady, pulseNumFault, eeCrcFault, devState, burstStart, burstActive} = '0;
    {driveInputOne, driveInputTwo} = '0;
    sd = $urandom(5325);
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      sh[k] = RS[k];
      acc(1'b1, AD[k], 8'h00);
      chk({8'h0, r[7:0]}, {8'h0, RS[k]});
    end
    outs();
    // All-ones corners first, then random writes
    for (int n = 0; n < 24; n++) begin
      i = (n < 5) ? n : int'($urandom_range(4));
      d = (n < 5) ? 8'hff : 8'($urandom);
      {filterFreqCode, filterBypass, trimOverride, factorySlope, factoryIntercept} <=
        15'($urandom);
      {vdrvReady, pulseNumFault, eeCrcFault, devState} <= 5'($urandom);
      acc(1'b0, AD[i], d);
      sh[i] = d & MK[i];
      acc(1'b1, AD[i], 8'h00);
      chk({8'h0, r[7:0]}, {8'h0, sh[i]});
      chk(16'(r[14:9]), 16'({vdrvReady, pulseNumFault, 1'b0, eeCrcFault, devState}));
      chk(16'(^r), 16'h1);
      outs();
    end
    // Bad parity must not write and is flagged next
    m.xfer(fr(1'b0, FEC_OFFSET, 8'h81) ^ 16'h0100, r);
    acc(1'b1, FEC_OFFSET, 8'h00);
    chk({r[15], 7'h0, r[7:0]}, {1'b1, 7'h0, sh[2]});
    // Every deglitch code, just before and after its limit
    for (int c = 0; c < 8; c++) begin
      arm(2'h0, 3'(c));
      wt(LM[c] - 12, 1'b1, 1'b0);
      chk(16'(driveStuckFault), 16'h0);
      wt(24, 1'b0, 1'b0);
      chk(16'(driveStuckFault), 16'(c != 7));
      clr(c != 7);
    end
    probe(2'h1, 1'b0, 1'b1, 800, 1'b0);
    // Idle input must end low after the arm toggle, else both-high masks the fault
    driveInputOne <= 1'b1;
    probe(2'h2, 1'b0, 1'b1, 440, 1'b1);
    driveInputTwo <= 1'b1;
    probe(2'h2, 1'b1, 1'b0, 440, 1'b1);
    driveInputOne <= 1'b0;
    driveInputTwo <= 1'b0;
    @(posedge mclk);
    probe(2'h2, 1'b0, 1'b0, 700, 1'b0);
    probe(2'h3, 1'b0, 1'b0, 700, 1'b0);
    test_done();
  end
endmodule // usf_config_regs_tb_top
`default_nettype wire

/* usf_drive_monitor.sv */
// Stuck-drive watchdog on drive input two, or on both drive inputs in dual mode
`timescale 1ns/1ps
`default_nettype none
module usf_drive_monitor
  import usf_pkg::*;
#(
  parameter int LONG_CYC = DG_C0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] ioMode,
  input wire logic [2:0] dgCode,
  input wire logic burstStart,
  input wire logic burstActive,
  input wire logic [1:0] driveIn,
  output logic stuckPulse
);
  logic armed;
  logic [1:0] drivePrev;
  logic [12:0] limit;
  wire logic bothHigh;
  wire logic checkOn;
  wire logic [1:0] expired;
  wire logic [1:0] watched;

  always_comb begin
    case (dgCode)
      3'h0: limit = 13'(LONG_CYC);
      3'h1: limit = 13'(DG_C1);
      3'h2: limit = 13'(DG_C2);
      3'h3: limit = 13'(DG_C3);
      3'h4: limit = 13'(DG_C4);
      3'h5: limit = 13'(DG_C5);
      3'h6: limit = 13'(DG_C6);
      default: limit = 13'h0000;
    endcase
  end

  assign checkOn = armed && dgCode != DG_OFF_CODE && ioMode != IO_MODE_NONE;
  assign bothHigh = (ioMode == IO_MODE_DUAL) && (&driveIn);
  assign watched = (ioMode == IO_MODE_DUAL) ? 2'b11 : 2'b10;

  always_ff @(posedge mclk) begin
    if (sys_rst) armed <= 1'b0;
    else armed <= burstStart | (armed & burstActive);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) drivePrev <= 2'b00;
    else drivePrev <= driveIn;
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_timer
      logic [12:0] idleCnt;
      always_ff @(posedge mclk) begin
        if (sys_rst) idleCnt <= 13'h0000;
        else if (!checkOn || burstStart || bothHigh || driveIn[ch] != drivePrev[ch])
          idleCnt <= 13'h0000;
        else if (idleCnt != limit) idleCnt <= idleCnt + 13'h0001;
      end
      assign expired[ch] = checkOn && watched[ch] && idleCnt == limit;
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (sys_rst) stuckPulse <= 1'b0;
    else stuckPulse <= (|expired) && !bothHigh;
  end
endmodule // usf_drive_monitor
`default_nettype wire

/* usf_pkg.sv */
// Shared constants for the ultrasonic front-end configuration bank
package usf_pkg;

  // ************
  // Clock and frame
  // ************
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 6;
  localparam logic CMD_READ = 1'b1;

  // ************
  // Register offsets
  // ************
  localparam logic [5:0] FC2_OFFSET = 6'h11;
  localparam logic [5:0] LAC_OFFSET = 6'h12;
  localparam logic [5:0] FEC_OFFSET = 6'h13;
  localparam logic [5:0] DIO_OFFSET = 6'h14;
  localparam logic [5:0] DSC_OFFSET = 6'h16;
  localparam logic [5:0] FLT_OFFSET = 6'h1c;

  // ************
  // Reset values and writable masks
  // ************
  localparam logic [7:0] FC2_RESET = 8'h00;
  localparam logic [7:0] LAC_RESET = 8'h00;
  localparam logic [7:0] FEC_RESET = 8'h00;
  localparam logic [7:0] DIO_RESET = 8'h00;
  localparam logic [7:0] DSC_RESET = 8'h20;
  localparam logic [7:0] FC2_MASK = 8'h3f;
  localparam logic [7:0] LAC_MASK = 8'hff;
  localparam logic [7:0] FEC_MASK = 8'hc7;
  localparam logic [7:0] DIO_MASK = 8'h1f;
  localparam logic [7:0] DSC_MASK = 8'h7f;

  // ************
  // Field positions
  // ************
  localparam int FC2_Q_LSB = 4;
  localparam int FC2_TRIM_LSB = 0;
  localparam int LAC_OVR_BIT = 7;
  localparam int LAC_SLOPE_LSB = 4;
  localparam int LAC_INT_LSB = 0;
  localparam int FEC_FIRST_BIT = 7;
  localparam int FEC_LAST_BIT = 6;
  localparam int FEC_SCALE_BIT = 2;
  localparam int FEC_GAIN_LSB = 0;
  localparam int DIO_DG_LSB = 2;
  localparam int DIO_MODE_LSB = 0;
  localparam int STAT_STUCK_BIT = 3;
  localparam int FLT_STUCK_BIT = 3;

  // ************
  // Deglitch times
  // ************
  localparam int DG_T0_US = 64;
  localparam int DG_T1_US = 48;
  localparam int DG_T2_US = 32;
  localparam int DG_T3_US = 24;
  localparam int DG_T4_US = 16;
  localparam int DG_T5_US = 8;
  localparam int DG_T6_US = 4;
  localparam int DG_C0 = DG_T0_US * 1000 / CLK_PERIOD_NS;
  localparam int DG_C1 = DG_T1_US * 1000 / CLK_PERIOD_NS;
  localparam int DG_C2 = DG_T2_US * 1000 / CLK_PERIOD_NS;
  localparam int DG_C3 = DG_T3_US * 1000 / CLK_PERIOD_NS;
  localparam int DG_C4 = DG_T4_US * 1000 / CLK_PERIOD_NS;
  localparam int DG_C5 = DG_T5_US * 1000 / CLK_PERIOD_NS;
  localparam int DG_C6 = DG_T6_US * 1000 / CLK_PERIOD_NS;
  localparam logic [2:0] DG_OFF_CODE = 3'h7;
  localparam logic [1:0] IO_MODE_DUAL = 2'h2;
  localparam logic [1:0] IO_MODE_NONE = 2'h3;

  // ************
  // Serial frame states
  // ************
  typedef enum logic [1:0] {
    USF_IDLE = 2'b00,
    USF_SHIFT = 2'b01,
    USF_CLOSE = 2'b11
  } usf_frame_state_t;

endpackage

/* usf_slope_lut.sv */
// Registered slope lookup in hundredths of V/V
`timescale 1ns/1ps
`default_nettype none
module usf_slope_lut (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scaleHigh,
  input wire logic [2:0] slopeCode,
  output logic [9:0] slopeCenti
);
  // ************
  // Table
  // ************
  localparam logic [159:0] LUT = {
    10'd440, 10'd425, 10'd410, 10'd394, 10'd501, 10'd486, 10'd471, 10'd456,
    10'd290, 10'd280, 10'd270, 10'd260, 10'd330, 10'd320, 10'd310, 10'd300};

  wire logic [3:0] lutIndex;
  wire logic [9:0] lutWord;
  assign lutIndex = {scaleHigh, slopeCode};
  assign lutWord = LUT[lutIndex * 10 +: 10];

  always_ff @(posedge mclk) begin
    if (sys_rst) slopeCenti <= 10'h12c;
    else slopeCenti <= lutWord;
  end
endmodule // usf_slope_lut
`default_nettype wire

/* usf_spi_ctrl_model.sv */
// Behavioural serial controller facing the bank
`timescale 1ns/1ps
`default_nettype none
module usf_spi_ctrl_model (
  input wire logic mclk,
  input wire logic spiDataOut,
  output logic spiSelN,
  output logic spiClk,
  output logic spiDataIn
);
  initial begin
    spiSelN = 1'b1;
    spiClk = 1'b0;
    spiDataIn = 1'b0;
  end

  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(posedge mclk);
    spiSelN <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int i = 15; i >= 0; i--) begin
      spiClk <= 1'b1;
      spiDataIn <= w[i];
      repeat (3) @(posedge mclk);
      r[i] = spiDataOut;
      spiClk <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    spiSelN <= 1'b1;
    // Released line must not keep the last bit
    spiDataIn <= ~spiDataIn;
    repeat (5) @(posedge mclk);
  endtask
endmodule // usf_spi_ctrl_model
`default_nettype wire
